// ===== hw/adc_channel_cal_regs.v
// channel calibration and input select register bank behind an axi4-lite slave
`timescale 1ns/100ps
`default_nettype none
`include "adc_cal_defs.vh"

module adc_channel_cal_regs (
    input  wire        clk,
    input  wire        srst,
    // axi4-lite write address
    input  wire [6:0]  s_axi_awaddr,
    input  wire [2:0]  s_axi_awprot,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read address
    input  wire [6:0]  s_axi_araddr,
    input  wire [2:0]  s_axi_arprot,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    // axi4-lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // correction words and source select toward the conversion path
    output reg  [1:0]  inputSourceCode,
    output reg         selectPinPair,
    output reg         selectShorted,
    output reg         selectTestPos,
    output reg         selectTestNeg,
    output reg  [23:0] offsetWord,
    output reg  [23:0] gainWord,
    output reg  [7:0]  firstGainWordLowPart
);

    // held write address and data; either may arrive first
    reg        awHeld_q;
    reg        wHeld_q;
    reg [4:0]  awIdx_q;
    reg [31:0] wData_q;
    reg [3:0]  wStrb_q;

    // register storage
    reg [1:0]  inputSourceCode_q;
    reg        selRsvdBit_q;
    reg [9:0]  selRsvdHigh_q;
    reg [15:0] offsetWordHighPart_q;
    reg [7:0]  offsetWordLowPart_q;
    reg [15:0] gainWordHighPart_q;
    reg [7:0]  gainWordLowPart_q;
    reg [7:0]  firstGainWordLowPart_q;

    // field reset values carved from the whole-register reset words
    localparam [15:0] SEL_RST_WORD   = `INPUT_SEL_RST;
    localparam [15:0] OFS_LOW_WORD   = `OFS_LOWER_RST;
    localparam [15:0] GAIN_LOW_WORD  = `GAIN_LOWER_RST;
    localparam [15:0] FIRST_LOW_WORD = `FIRST_GAIN_LOWER_RST;
    localparam [1:0]  SEL_CODE_RST   = SEL_RST_WORD[`SEL_CODE_HI:`SEL_CODE_LO];
    localparam [0:0]  SEL_BIT_RST    = SEL_RST_WORD[`SEL_RSVD_BIT];
    localparam [9:0]  SEL_HIGH_RST   = SEL_RST_WORD[`SEL_RSVD_HI:`SEL_RSVD_LO];
    localparam [7:0]  OFS_LOW_RST    = OFS_LOW_WORD[`LOW_PART_HI:`LOW_PART_LO];
    localparam [7:0]  GAIN_LOW_RST   = GAIN_LOW_WORD[`LOW_PART_HI:`LOW_PART_LO];
    localparam [7:0]  FIRST_LOW_RST  = FIRST_LOW_WORD[`LOW_PART_HI:`LOW_PART_LO];
    // whole correction words after reset, as the datapath must see them
    localparam [23:0] OFS_WORD_RST   = {`OFS_UPPER_RST, OFS_LOW_RST};
    localparam [23:0] GAIN_WORD_RST  = {`GAIN_UPPER_RST, GAIN_LOW_RST};

    wire       doWrite;
    wire [4:0] arIdx;
    wire       arAligned;
    wire       awAligned;
    reg        awAligned_q;
    reg [15:0] readWord;
    reg        readHit;
    reg        writeHit;
    reg [15:0] newHalf;

    // accept each channel once until the response is taken
    assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    // byte address is four times the register index; low two bits must be zero
    assign awAligned = (s_axi_awaddr[1:0] == 2'h0);
    assign arAligned = (s_axi_araddr[1:0] == 2'h0);
    assign arIdx     = s_axi_araddr[6:2];

    // the write commits once both address and data are held
    assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;

    // write address channel, held until the write commits
    always @(posedge clk) begin
        if (srst) begin
            awHeld_q    <= 1'b0;
            awIdx_q     <= 5'h00;
            awAligned_q <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHeld_q    <= 1'b1;
            awIdx_q     <= s_axi_awaddr[6:2];
            awAligned_q <= awAligned;
        end else if (doWrite) begin
            awHeld_q <= 1'b0;
        end
    end

    // write data channel, held apart so it may lead or trail the address
    always @(posedge clk) begin
        if (srst) begin
            wHeld_q <= 1'b0;
            wData_q <= 32'h00000000;
            wStrb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
        end else if (doWrite) begin
            wHeld_q <= 1'b0;
        end
    end

    // merge byte lanes 0 and 1 into the current register value
    always @* begin
        writeHit = awAligned_q;
        case (awIdx_q)
            `FIRST_GAIN_LOWER_IDX:  newHalf = {firstGainWordLowPart_q, 8'h00};
            `SECOND_INPUT_SEL_IDX:  newHalf = {selRsvdHigh_q, 3'h0, selRsvdBit_q,
                                               inputSourceCode_q};
            `SECOND_OFS_UPPER_IDX:  newHalf = offsetWordHighPart_q;
            `SECOND_OFS_LOWER_IDX:  newHalf = {offsetWordLowPart_q, 8'h00};
            `SECOND_GAIN_UPPER_IDX: newHalf = gainWordHighPart_q;
            `SECOND_GAIN_LOWER_IDX: newHalf = {gainWordLowPart_q, 8'h00};
            default: begin
                newHalf  = 16'h0000;
                writeHit = 1'b0;
            end
        endcase
        // strobes 2 and 3 cover no stored bits and are ignored
        if (wStrb_q[0]) begin
            newHalf[7:0] = wData_q[7:0];
        end
        if (wStrb_q[1]) begin
            newHalf[15:8] = wData_q[15:8];
        end
    end

    // one write enable per register; unmapped or misaligned writes raise none
    wire wrFirstGainLower = doWrite && writeHit && (awIdx_q == `FIRST_GAIN_LOWER_IDX);
    wire wrInputSel       = doWrite && writeHit && (awIdx_q == `SECOND_INPUT_SEL_IDX);
    wire wrOfsUpper       = doWrite && writeHit && (awIdx_q == `SECOND_OFS_UPPER_IDX);
    wire wrOfsLower       = doWrite && writeHit && (awIdx_q == `SECOND_OFS_LOWER_IDX);
    wire wrGainUpper      = doWrite && writeHit && (awIdx_q == `SECOND_GAIN_UPPER_IDX);
    wire wrGainLower      = doWrite && writeHit && (awIdx_q == `SECOND_GAIN_LOWER_IDX);

    // first channel gain low byte
    always @(posedge clk) begin
        if (srst) begin
            firstGainWordLowPart_q <= FIRST_LOW_RST;
        end else if (wrFirstGainLower) begin
            firstGainWordLowPart_q <= newHalf[`LOW_PART_HI:`LOW_PART_LO];
        end
    end

    // input select; reserved bits stored as written, software keeps them zero
    always @(posedge clk) begin
        if (srst) begin
            inputSourceCode_q <= SEL_CODE_RST;
            selRsvdBit_q      <= SEL_BIT_RST;
            selRsvdHigh_q     <= SEL_HIGH_RST;
        end else if (wrInputSel) begin
            inputSourceCode_q <= newHalf[`SEL_CODE_HI:`SEL_CODE_LO];
            selRsvdBit_q      <= newHalf[`SEL_RSVD_BIT];
            selRsvdHigh_q     <= newHalf[`SEL_RSVD_HI:`SEL_RSVD_LO];
        end
    end

    // offset upper half, all sixteen bits writable
    always @(posedge clk) begin
        if (srst) begin
            offsetWordHighPart_q <= `OFS_UPPER_RST;
        end else if (wrOfsUpper) begin
            offsetWordHighPart_q <= newHalf;
        end
    end

    // offset low byte; the low half of the register is never stored
    always @(posedge clk) begin
        if (srst) begin
            offsetWordLowPart_q <= OFS_LOW_RST;
        end else if (wrOfsLower) begin
            offsetWordLowPart_q <= newHalf[`LOW_PART_HI:`LOW_PART_LO];
        end
    end

    // gain upper half; resets to unity gain
    always @(posedge clk) begin
        if (srst) begin
            gainWordHighPart_q <= `GAIN_UPPER_RST;
        end else if (wrGainUpper) begin
            gainWordHighPart_q <= newHalf;
        end
    end

    // gain low byte
    always @(posedge clk) begin
        if (srst) begin
            gainWordLowPart_q <= GAIN_LOW_RST;
        end else if (wrGainLower) begin
            gainWordLowPart_q <= newHalf[`LOW_PART_HI:`LOW_PART_LO];
        end
    end

    // write response valid, one cycle after both halves are held
    always @(posedge clk) begin
        if (srst) begin
            s_axi_bvalid <= 1'b0;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // write response code, steady while the response waits
    always @(posedge clk) begin
        if (srst) begin
            s_axi_bresp <= `RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bresp <= writeHit ? `RESP_OKAY : `RESP_SLVERR;
        end
    end

    // read mux; read-only reserved bits always return zero
    always @* begin
        readHit = arAligned;
        case (arIdx)
            `FIRST_GAIN_LOWER_IDX:  readWord = {firstGainWordLowPart_q, 8'h00};
            `SECOND_INPUT_SEL_IDX:  readWord = {selRsvdHigh_q, 3'h0, selRsvdBit_q,
                                                inputSourceCode_q};
            `SECOND_OFS_UPPER_IDX:  readWord = offsetWordHighPart_q;
            `SECOND_OFS_LOWER_IDX:  readWord = {offsetWordLowPart_q, 8'h00};
            `SECOND_GAIN_UPPER_IDX: readWord = gainWordHighPart_q;
            `SECOND_GAIN_LOWER_IDX: readWord = {gainWordLowPart_q, 8'h00};
            default: begin
                readWord = 16'h0000;
                readHit  = 1'b0;
            end
        endcase
        if (!arAligned) begin
            readWord = 16'h0000;
        end
    end

    // read valid, one cycle after the address is taken, until rready
    always @(posedge clk) begin
        if (srst) begin
            s_axi_rvalid <= 1'b0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // read data and code, captured once and held while the answer waits
    always @(posedge clk) begin
        if (srst) begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rdata <= {16'h0000, readWord};
            s_axi_rresp <= readHit ? `RESP_OKAY : `RESP_SLVERR;
        end
    end

    // source select decode toward the input switches
    // registered so the switches never see a glitch while the code changes
    always @(posedge clk) begin
        if (srst) begin
            inputSourceCode <= SEL_CODE_RST;
            selectPinPair   <= (SEL_CODE_RST == `SRC_NORMAL);
            selectShorted   <= (SEL_CODE_RST == `SRC_SHORTED);
            selectTestPos   <= (SEL_CODE_RST == `SRC_TEST_POS);
            selectTestNeg   <= (SEL_CODE_RST == `SRC_TEST_NEG);
        end else begin
            inputSourceCode <= inputSourceCode_q;
            selectPinPair   <= (inputSourceCode_q == `SRC_NORMAL);
            selectShorted   <= (inputSourceCode_q == `SRC_SHORTED);
            selectTestPos   <= (inputSourceCode_q == `SRC_TEST_POS);
            selectTestNeg   <= (inputSourceCode_q == `SRC_TEST_NEG);
        end
    end

    // signed offset correction, upper half joined with the low byte
    // mixed for a while between the two half writes; update both while idle
    always @(posedge clk) begin
        if (srst) begin
            offsetWord <= OFS_WORD_RST;
        end else begin
            offsetWord <= {offsetWordHighPart_q, offsetWordLowPart_q};
        end
    end

    // unsigned gain correction, top bit alone meaning a gain of one
    always @(posedge clk) begin
        if (srst) begin
            gainWord <= GAIN_WORD_RST;
        end else begin
            gainWord <= {gainWordHighPart_q, gainWordLowPart_q};
        end
    end

    // first channel gain low byte, passed on for its own datapath
    always @(posedge clk) begin
        if (srst) begin
            firstGainWordLowPart <= FIRST_LOW_RST;
        end else begin
            firstGainWordLowPart <= firstGainWordLowPart_q;
        end
    end

    // protection bits are accepted but carry no meaning here
    wire unusedProt = ^{s_axi_awprot, s_axi_arprot, wStrb_q[3:2], wData_q[31:16]};

endmodule // adc_channel_cal_regs

`default_nettype wire

// ===== hw/adc_cal_defs.vh
// register offsets, field positions and reset values for the channel calibration bank
`ifndef ADC_CAL_DEFS_VH
`define ADC_CAL_DEFS_VH

// register indices (not byte offsets: byte address = 4 * index)
`define FIRST_GAIN_LOWER_IDX    5'h0d
`define SECOND_INPUT_SEL_IDX    5'h0e
`define SECOND_OFS_UPPER_IDX    5'h0f
`define SECOND_OFS_LOWER_IDX    5'h10
`define SECOND_GAIN_UPPER_IDX   5'h11
`define SECOND_GAIN_LOWER_IDX   5'h12

// reset values
`define INPUT_SEL_RST           16'h0000
`define OFS_UPPER_RST           16'h0000
`define OFS_LOWER_RST           16'h0000
`define GAIN_UPPER_RST          16'h8000
`define GAIN_LOWER_RST          16'h0000
`define FIRST_GAIN_LOWER_RST    16'h0000

// input select register fields
`define SEL_CODE_HI             1
`define SEL_CODE_LO             0
`define SEL_RSVD_BIT            2
`define SEL_RO_HI               5
`define SEL_RO_LO               3
`define SEL_RSVD_HI             15
`define SEL_RSVD_LO             6

// lower correction registers: payload in the high byte
`define LOW_PART_HI             15
`define LOW_PART_LO             8

// input source codes
`define SRC_NORMAL              2'h0
`define SRC_SHORTED             2'h1
`define SRC_TEST_POS            2'h2
`define SRC_TEST_NEG            2'h3

// bus answers
`define RESP_OKAY               2'h0
`define RESP_SLVERR             2'h2

`endif

// ===== tb/adc_cal_props.sv
// assertion checker for the channel calibration register bank
`timescale 1ns/100ps
`default_nettype none
module adc_cal_props (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic [6:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic [1:0]  inputSourceCode,
    input wire logic        selectPinPair,
    input wire logic        selectShorted,
    input wire logic        selectTestPos,
    input wire logic        selectTestNeg,
    input wire logic [23:0] offsetWord,
    input wire logic [23:0] gainWord
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // both write channels taken on one edge, as the bench offers them
    wire logic bothTaken = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

    sel_decode_a: assert property (
        {selectTestNeg, selectTestPos, selectShorted, selectPinPair} == 4'h1 << inputSourceCode)
        else $error("source decode wrong");
    reset_value_a: assert property (
        $fell(srst) |-> gainWord == 24'h800000 && offsetWord == 24'h000000 && selectPinPair)
        else $error("values after reset wrong");
    rdata_upper_a: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000) else $error("read data upper not zero");
    ar_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
    ar_block_a: assert property (
        s_axi_rvalid |-> !s_axi_arready) else $error("read address taken while busy");
    aw_block_a: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
    wr_answer_a: assert property (
        bothTaken |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer timing wrong");
    gain_update_a: assert property (
        bothTaken && s_axi_awaddr == 7'h44 && s_axi_wstrb[1:0] == 2'h3
        |-> ##3 gainWord[23:8] == $past(s_axi_wdata[15:0], 3)) else $error("gain word not updated");

    // main scenarios reached
    cover property (bothTaken);
    cover property (selectTestNeg);
    cover property (s_axi_rvalid && s_axi_rdata[15:0] == 16'h8000);
endmodule // adc_cal_props

bind adc_channel_cal_regs adc_cal_props checker_u (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .inputSourceCode,
    .selectPinPair, .selectShorted, .selectTestPos, .selectTestNeg, .offsetWord, .gainWord);
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the channel calibration register bank
`timescale 1ns/100ps
`default_nettype none
`include "adc_cal_defs.vh"
module tb_top;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [6:0]  s_axi_awaddr = 7'h00;
    logic [6:0]  s_axi_araddr = 7'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic   selectPinPair, selectShorted, selectTestPos, selectTestNeg;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp, inputSourceCode;
    wire logic [31:0] s_axi_rdata;
    wire logic [23:0] offsetWord, gainWord;
    wire logic [7:0]  firstGainWordLowPart;
    int          fails = 0;
    int          total_checks = 0;

    always #25 clk = ~clk;

    // responses always accepted at once, so no stall cases here
    adc_channel_cal_regs dut_u (.clk, .srst, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1),
        .inputSourceCode, .selectPinPair, .selectShorted, .selectTestPos, .selectTestNeg,
        .offsetWord, .gainWord, .firstGainWordLowPart);

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // readys sampled at the falling edge hold until the next rising edge
    task automatic wr(input logic [6:0] a, input logic [15:0] d, input logic [3:0] st,
                      input logic [1:0] er);
        logic ta, tw, tb;
        logic [1:0] r;
        tb = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, d};
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!tb) begin
            @(negedge clk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        chk("bresp", {30'h0, r}, {30'h0, er});
    endtask

    task automatic rd(input logic [6:0] a, input logic [15:0] exp, input logic [1:0] er);
        logic ta, tr;
        logic [31:0] d;
        logic [1:0] r;
        tr = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        while (!tr) begin
            @(negedge clk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk);
            if (ta) s_axi_arvalid <= 1'b0;
        end
        chk("rdata", d, {16'h0000, exp});
        chk("rresp", {30'h0, r}, {30'h0, er});
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // 32 accesses of a few cycles each
    initial begin
        repeat (4000) @(posedge clk);
        fails++;
        close_out();
    end

    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            rd(7'h34 + 7'(4 * i), (i == 4) ? 16'h8000 : 16'h0, 2'h0);
        end
        chk("gainWord", {8'h00, gainWord}, 32'h0080_0000);
        $display("reset values done");
        for (int c = 0; c < 4; c++) begin
            wr(7'h38, 16'h0038 | 16'(c), 4'h3, 2'h0);
            rd(7'h38, 16'(c), 2'h0);
            chk("sources", {28'h0, selectTestNeg, selectTestPos, selectShorted,
                selectPinPair}, 32'h1 << c);
            chk("inputSourceCode", {30'h0, inputSourceCode}, 32'(c));
        end
        $display("input select done");
        wr(7'h3c, 16'hfedc, 4'h3, 2'h0);
        wr(7'h40, 16'hbaff, 4'h3, 2'h0);
        rd(7'h3c, 16'hfedc, 2'h0);
        rd(7'h40, 16'hba00, 2'h0);
        chk("offsetWord", {8'h00, offsetWord}, 32'h00fe_dcba);
        wr(7'h44, 16'h1234, 4'h1, 2'h0);
        wr(7'h48, 16'h56ff, 4'h3, 2'h0);
        rd(7'h44, 16'h8034, 2'h0);
        rd(7'h48, 16'h5600, 2'h0);
        chk("gainWord", {8'h00, gainWord}, 32'h0080_3456);
        wr(7'h34, 16'h9a77, 4'h3, 2'h0);
        rd(7'h34, 16'h9a00, 2'h0);
        chk("firstGain", {24'h0, firstGainWordLowPart}, 32'h9a);
        $display("corrections done");
        wr(7'h4c, 16'hffff, 4'h3, 2'h2);
        rd(7'h4c, 16'h0000, 2'h2);
        rd(7'h39, 16'h0000, 2'h2);
        rd(7'h44, 16'h8034, 2'h0);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd(7'h44, 16'h8000, 2'h0);
        rd(7'h38, 16'h0000, 2'h0);
        wr(7'h44, 16'h7f01, 4'h3, 2'h0);
        rd(7'h44, 16'h7f01, 2'h0);
        chk("gainWord", {8'h00, gainWord}, 32'h007f_0100);
        $display("refusals and second reset done");
        close_out();
    end
endmodule // tb_top
`default_nettype wire
